// [pic_core_model.sv]
`timescale 1ns/1ns
module pic_core_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic irq_req,
    input wire logic [2:0] requested_priority,
    input wire logic slow,
    input wire logic done,
    output logic [2:0] core_current_priority
);
    int wait_q;
    logic [2:0] saved_q;
    // The core raises its level to the one it took, as a handler entry does.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            core_current_priority <= 3'h0;
            saved_q <= 3'h0;
            wait_q <= 0;
        end
        else if (done)
            core_current_priority <= saved_q;
        else if (irq_req && requested_priority > core_current_priority)
        begin
            if (wait_q >= (slow ? 3 : 0))
            begin
                saved_q <= core_current_priority;
                core_current_priority <= requested_priority;
                wait_q <= 0;
            end
            else
                wait_q <= wait_q + 1;
        end
    end
endmodule

// [pic_monitor.sv]
`timescale 1ns/1ns
module pic_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic [4:0] external_request_inputs,
    input wire logic [2:0] periph_req,
    input wire logic [2:0] core_current_priority,
    input wire logic irq_req,
    input wire logic [5:0] irq_vector,
    input wire logic [2:0] requested_priority,
    input wire logic irq_use_shadow_set
);
    logic multi_vector_select_q;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            multi_vector_select_q <= 1'b0;
        else if (psel && penable && pready && pwrite && paddr == 8'h00)
            multi_vector_select_q <= pwdata[12];
    end
    fwd_above_core_a: assert property (irq_req |-> requested_priority > $past(core_current_priority))
        else $error("request not above core");
    top_level_block_a: assert property (core_current_priority == 3'h7 |=> !irq_req)
        else $error("request above top level");
    reset_single_a: assert property ($rose(presetn) |-> irq_vector == 6'h00 && !irq_req)
        else $error("bad outputs after reset");
    single_vec_a: assert property (irq_req && !multi_vector_select_q && !$past(multi_vector_select_q) |-> irq_vector == 6'h00)
        else $error("nonzero single vector");
    vec_range_a: assert property (irq_req |-> irq_vector < 6'h08)
        else $error("vector out of range");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready too long");
    wait_state_a: assert property (psel && penable && !pready |=> pready)
        else $error("ready late");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    cover property (irq_req && multi_vector_select_q);
    cover property (pslverr);
    cover property (irq_req && irq_use_shadow_set);
endmodule
bind pic_top pic_monitor i_mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .external_request_inputs(external_request_inputs), .periph_req(periph_req),
    .core_current_priority(core_current_priority), .irq_req(irq_req), .irq_vector(irq_vector),
    .requested_priority(requested_priority), .irq_use_shadow_set(irq_use_shadow_set));

// [pic_pkg.sv]
package pic_pkg;

    // Source layout: external request inputs first, then on-chip requests.
    localparam int NUM_EXT = 5;
    localparam int NUM_INT = 3;
    localparam int NUM_SRC = 8;
    localparam int PRI_W = 3;
    localparam int SUB_W = 2;
    localparam int VEC_W = 6;
    localparam int ADDR_W = 8;

    // Register byte addresses.
    localparam logic [7:0] OFF_INTERRUPT_CONTROL_REGISTER = 8'h00;
    localparam logic [7:0] OFF_FLAG = 8'h04;
    localparam logic [7:0] OFF_ENABLE = 8'h08;
    localparam logic [7:0] OFF_PRIO0 = 8'h0c;
    localparam logic [7:0] OFF_PRIO1 = 8'h10;
    localparam logic [7:0] OFF_TRELOAD = 8'h14;
    localparam logic [7:0] OFF_TCOUNT = 8'h18;
    localparam logic [7:0] OFF_SHADOW = 8'h1c;
    localparam logic [7:0] OFF_STATUS = 8'h20;

    // Control register fields.
    localparam int POL_LSB = 0;
    localparam int TPC_LSB = 8;
    localparam int MULTI_VECTOR_SELECT_BIT = 12;

    // Priority register fields: one byte per source, four sources a word.
    localparam int PRIO_STRIDE = 8;
    localparam int PRIO_PER_WORD = 4;
    localparam int PRI_LSB = 2;
    localparam int SUB_LSB = 0;

    // Status register fields.
    localparam int ST_REQ_BIT = 0;
    localparam int ST_TRUN_BIT = 1;
    localparam int ST_SHADOW_BIT = 2;
    localparam int ST_PRI_LSB = 4;
    localparam int ST_VEC_LSB = 8;

    // Reset values.
    localparam logic [NUM_EXT-1:0] POL_RST = 5'h00;
    localparam logic [NUM_EXT-1:0] ADJ_PREV_RST = 5'h1f;
    localparam logic [PRI_W-1:0] TPC_RST = 3'h0;
    localparam logic MULTI_VECTOR_SELECT_RST = 1'b0;
    localparam logic [31:0] TRELOAD_RST = 32'h0000_0000;

    typedef struct packed {
        logic [NUM_EXT-1:0] sync1;
        logic [NUM_EXT-1:0] sync2;
        logic [NUM_EXT-1:0] adj_prev;
        logic [NUM_EXT-1:0] pol;
        logic [PRI_W-1:0] coalescing_priority_level;
        logic multi_vector_select;
        logic [NUM_SRC-1:0] flag;
        logic [NUM_SRC-1:0] en;
        logic [NUM_SRC-1:0][PRI_W-1:0] prio;
        logic [NUM_SRC-1:0][SUB_W-1:0] sub;
        logic [7:0] shadow;
        logic [31:0] reload;
        logic [31:0] tcnt;
        logic trun;
        logic irq_req;
        logic [VEC_W-1:0] irq_vec;
        logic [PRI_W-1:0] irq_pri;
        logic irq_shadow;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } pic_state_t;

endpackage

// [pic_top.sv]
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/1ns
module pic_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pic_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic [pic_pkg::NUM_EXT-1:0] external_request_inputs,
    input wire logic [pic_pkg::NUM_INT-1:0] periph_req,
    input wire logic [pic_pkg::PRI_W-1:0] core_current_priority,
    output logic irq_req,
    output logic [pic_pkg::VEC_W-1:0] irq_vector,
    output logic [pic_pkg::PRI_W-1:0] requested_priority,
    output logic irq_use_shadow_set
);

    ////////////////////////////////////////////////////////////////////////////
    // State and helpers.

    // All state sits in one packed struct: n is the next value, s the register.
    pic_pkg::pic_state_t s;
    pic_pkg::pic_state_t n;

    logic access;
    logic wr_done;
    logic mapped;
    logic [31:0] rd_word;
    logic [pic_pkg::NUM_EXT-1:0] adj;
    logic [pic_pkg::NUM_EXT-1:0] ext_edge;
    logic [pic_pkg::NUM_SRC-1:0] set_vec;
    logic [pic_pkg::NUM_SRC-1:0] clr_vec;
    logic [pic_pkg::NUM_SRC-1:0] low_mask;
    logic trigger;
    logic found;
    logic [pic_pkg::PRI_W-1:0] best_pri;
    logic [pic_pkg::SUB_W-1:0] best_sub;
    logic [pic_pkg::VEC_W-1:0] best_idx;
    logic eligible;

    // Packs four sources' priority and subpriority into one register word.
    function automatic logic [31:0] prio_word(
        input logic [pic_pkg::NUM_SRC-1:0][pic_pkg::PRI_W-1:0] pr,
        input logic [pic_pkg::NUM_SRC-1:0][pic_pkg::SUB_W-1:0] sb,
        input int base
    );
        logic [31:0] w;
        w = '0;
        for (int k = 0; k < pic_pkg::PRIO_PER_WORD; k++)
        begin
            w[k*pic_pkg::PRIO_STRIDE+pic_pkg::PRI_LSB +: pic_pkg::PRI_W] = pr[base+k];
            w[k*pic_pkg::PRIO_STRIDE+pic_pkg::SUB_LSB +: pic_pkg::SUB_W] = sb[base+k];
        end
        return w;
    endfunction

    // A source belongs to the coalescing group, enabled or not, when its nonzero
    // priority is at or below a nonzero coalescing level.
    function automatic logic in_group(
        input logic [pic_pkg::PRI_W-1:0] pr,
        input logic [pic_pkg::PRI_W-1:0] lvl
    );
        return (lvl != '0) && (pr != '0) && (pr <= lvl);
    endfunction

    // Pulls one source's priority out of a priority register word.
    function automatic logic [pic_pkg::PRI_W-1:0] prio_field(
        input logic [31:0] w,
        input int k
    );
        return w[k*pic_pkg::PRIO_STRIDE+pic_pkg::PRI_LSB +: pic_pkg::PRI_W];
    endfunction

    // Pulls one source's subpriority out of a priority register word.
    function automatic logic [pic_pkg::SUB_W-1:0] sub_field(
        input logic [31:0] w,
        input int k
    );
        return w[k*pic_pkg::PRIO_STRIDE+pic_pkg::SUB_LSB +: pic_pkg::SUB_W];
    endfunction

    // Orders two candidates by priority, then subpriority. A tie does not
    // win, so among equals the lowest source number keeps the grant.
    function automatic logic beats(
        input logic [pic_pkg::PRI_W-1:0] pr_a,
        input logic [pic_pkg::SUB_W-1:0] sb_a,
        input logic [pic_pkg::PRI_W-1:0] pr_b,
        input logic [pic_pkg::SUB_W-1:0] sb_b
    );
        return (pr_a > pr_b) || (pr_a == pr_b && sb_a > sb_b);
    endfunction

    // Gathers the control register fields into their read-back word.
    function automatic logic [31:0] interrupt_control_register_word(
        input logic [pic_pkg::NUM_EXT-1:0] pol,
        input logic [pic_pkg::PRI_W-1:0] coalescing_priority_level,
        input logic multi_vector_select
    );
        logic [31:0] w;
        w = '0;
        w[pic_pkg::POL_LSB +: pic_pkg::NUM_EXT] = pol;
        w[pic_pkg::TPC_LSB +: pic_pkg::PRI_W] = coalescing_priority_level;
        w[pic_pkg::MULTI_VECTOR_SELECT_BIT] = multi_vector_select;
        return w;
    endfunction

    // Gathers the live request and timer state into the status word.
    function automatic logic [31:0] status_word(
        input pic_pkg::pic_state_t st
    );
        logic [31:0] w;
        w = '0;
        w[pic_pkg::ST_REQ_BIT] = st.irq_req;
        w[pic_pkg::ST_TRUN_BIT] = st.trun;
        w[pic_pkg::ST_SHADOW_BIT] = st.irq_shadow;
        w[pic_pkg::ST_PRI_LSB +: pic_pkg::PRI_W] = st.irq_pri;
        w[pic_pkg::ST_VEC_LSB +: pic_pkg::VEC_W] = st.irq_vec;
        return w;
    endfunction

    // Folds the polarity bit into the synchronised level: 1 means active.
    function automatic logic [pic_pkg::NUM_EXT-1:0] active_level(
        input logic [pic_pkg::NUM_EXT-1:0] lvl,
        input logic [pic_pkg::NUM_EXT-1:0] pol
    );
        return lvl ^ ~pol;
    endfunction

    // Write-one-to-clear with set priority: an event in the same cycle as
    // its clear survives, so software never loses a request.
    function automatic logic [pic_pkg::NUM_SRC-1:0] flag_next(
        input logic [pic_pkg::NUM_SRC-1:0] flag,
        input logic [pic_pkg::NUM_SRC-1:0] set,
        input logic [pic_pkg::NUM_SRC-1:0] clr
    );
        return (flag & ~clr) | set;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Next state.

    always_comb
    begin
        n = s;

        // Bus decode; every access takes one wait state.
        // Unmapped addresses answer with an error and read as zero.
        access = psel & penable;
        wr_done = access & s.pready & pwrite;
        mapped = 1'b1;
        rd_word = '0;
        unique case (paddr)
            pic_pkg::OFF_INTERRUPT_CONTROL_REGISTER: rd_word = interrupt_control_register_word(s.pol, s.coalescing_priority_level, s.multi_vector_select);
            pic_pkg::OFF_FLAG: rd_word[pic_pkg::NUM_SRC-1:0] = s.flag;
            pic_pkg::OFF_ENABLE: rd_word[pic_pkg::NUM_SRC-1:0] = s.en;
            pic_pkg::OFF_PRIO0: rd_word = prio_word(s.prio, s.sub, 0);
            pic_pkg::OFF_PRIO1: rd_word = prio_word(s.prio, s.sub, pic_pkg::PRIO_PER_WORD);
            pic_pkg::OFF_TRELOAD: rd_word = s.reload;
            pic_pkg::OFF_TCOUNT: rd_word = s.tcnt;
            pic_pkg::OFF_SHADOW: rd_word[7:0] = s.shadow;
            pic_pkg::OFF_STATUS: rd_word = status_word(s);
            default: mapped = 1'b0;
        endcase

        // The access cycle registers the read word and raises pready, and
        // the next edge completes the transfer. pready lasts one cycle, but
        // an access held past it sees pready again two cycles later and is taken again.
        n.pready = access & ~s.pready;
        n.pslverr = access & ~s.pready & ~mapped;
        if (access & ~s.pready)
        begin
            n.prdata = pwrite ? 32'h0000_0000 : rd_word;
        end

        // Edge detection on synchronised pins. The polarity bit folds into
        // the level before the edge test, so flipping it can look like an
        // edge and set the flag.
        n.sync1 = external_request_inputs;
        n.sync2 = s.sync1;
        adj = active_level(s.sync2, s.pol);
        n.adj_prev = adj;
        ext_edge = adj & ~s.adj_prev;
        set_vec = {periph_req, ext_edge};

        // Flags are cleared by writing ones; a new event in the same cycle wins.
        clr_vec = '0;
        if (wr_done && paddr == pic_pkg::OFF_FLAG)
        begin
            clr_vec = pwdata[pic_pkg::NUM_SRC-1:0];
        end
        n.flag = flag_next(s.flag, set_vec, clr_vec);

        // Register writes land at the completing edge.
        // Read-only registers and unmapped addresses ignore writes.
        if (wr_done)
        begin
            unique case (paddr)
                pic_pkg::OFF_INTERRUPT_CONTROL_REGISTER:
                begin
                    n.pol = pwdata[pic_pkg::POL_LSB +: pic_pkg::NUM_EXT];
                    n.coalescing_priority_level = pwdata[pic_pkg::TPC_LSB +: pic_pkg::PRI_W];
                    n.multi_vector_select = pwdata[pic_pkg::MULTI_VECTOR_SELECT_BIT];
                end
                pic_pkg::OFF_ENABLE: n.en = pwdata[pic_pkg::NUM_SRC-1:0];
                pic_pkg::OFF_PRIO0, pic_pkg::OFF_PRIO1:
                begin
                    for (int k = 0; k < pic_pkg::PRIO_PER_WORD; k++)
                    begin
                        if (paddr == pic_pkg::OFF_PRIO0)
                        begin
                            n.prio[k] = prio_field(pwdata, k);
                            n.sub[k] = sub_field(pwdata, k);
                        end
                        else
                        begin
                            n.prio[k+pic_pkg::PRIO_PER_WORD] = prio_field(pwdata, k);
                            n.sub[k+pic_pkg::PRIO_PER_WORD] = sub_field(pwdata, k);
                        end
                    end
                end
                pic_pkg::OFF_TRELOAD: n.reload = pwdata;
                pic_pkg::OFF_SHADOW: n.shadow = {pwdata[7:1], 1'b0};
                default:
                begin
                end
            endcase
        end

        // Proximity timer. A group event while idle loads the reload value;
        // the window lasts reload plus one cycles and ends once the count
        // has reached zero. A zero reload never opens a window, and a
        // cleared level stops a running window at once.
        low_mask = '0;
        for (int i = 0; i < pic_pkg::NUM_SRC; i++)
        begin
            low_mask[i] = in_group(s.prio[i], s.coalescing_priority_level);
        end
        trigger = |(set_vec & low_mask);
        if (s.coalescing_priority_level == '0)
        begin
            n.trun = 1'b0;
            n.tcnt = '0;
        end
        else if (s.trun)
        begin
            if (s.tcnt == '0)
            begin
                n.trun = 1'b0;
            end
            else
            begin
                n.tcnt = s.tcnt - 32'h0000_0001;
            end
        end
        else if (trigger && s.reload != '0)
        begin
            n.trun = 1'b1;
            n.tcnt = s.reload;
        end

        // Arbitration: priority, then subpriority, then lowest source number.
        // Sources inside an open window are left out, as are disabled ones
        // and those whose priority is zero.
        found = 1'b0;
        best_pri = '0;
        best_sub = '0;
        best_idx = '0;
        for (int i = 0; i < pic_pkg::NUM_SRC; i++)
        begin
            eligible = s.flag[i] & s.en[i] & (s.prio[i] != '0)
                       & ~(s.trun & low_mask[i]);
            if (eligible && (!found || beats(s.prio[i], s.sub[i], best_pri, best_sub)))
            begin
                found = 1'b1;
                best_pri = s.prio[i];
                best_sub = s.sub[i];
                best_idx = pic_pkg::VEC_W'(i);
            end
        end

        // Request goes out on the cycle after the flag, with no added delay.
        // The core's level is compared every cycle, so raising it withdraws
        // the request one cycle later.
        n.irq_req = found && (best_pri > core_current_priority);
        n.irq_vec = s.multi_vector_select ? best_idx : '0;
        n.irq_pri = found ? best_pri : '0;
        n.irq_shadow = found & s.shadow[best_pri];
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register.

    // Reset leaves single-vector mode, falling-edge polarity and a stopped
    // timer. The previous level starts at the active value of a falling-edge
    // input, so a low pin gives no false edge after reset.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s <= '0;
            s.adj_prev <= pic_pkg::ADJ_PREV_RST;
            s.pol <= pic_pkg::POL_RST;
            s.coalescing_priority_level <= pic_pkg::TPC_RST;
            s.multi_vector_select <= pic_pkg::MULTI_VECTOR_SELECT_RST;
            s.reload <= pic_pkg::TRELOAD_RST;
        end
        else
        begin
            s <= n;
        end
    end

    // Every output is a register bit; nothing combinational reaches a pin.
    assign pready = s.pready;
    assign prdata = s.prdata;
    assign pslverr = s.pslverr;
    assign irq_req = s.irq_req;
    assign irq_vector = s.irq_vec;
    assign requested_priority = s.irq_pri;
    assign irq_use_shadow_set = s.irq_shadow;

endmodule

// [priority_interrupt_controller_bench.sv]
`timescale 1ns/1ns
module priority_interrupt_controller_bench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, shd, slow, done, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q, wd;
    logic [4:0] pins;
    logic [2:0] preq, cpri, rpri;
    logic [5:0] vec;
    int bad_count, cmp_count, seed, waited;
    int pri_m[8];

    pic_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .external_request_inputs(pins), .periph_req(preq), .core_current_priority(cpri),
        .irq_req(irq), .irq_vector(vec), .requested_priority(rpri), .irq_use_shadow_set(shd));
    pic_core_model i_core (.pclk(pclk), .presetn(presetn), .irq_req(irq), .requested_priority(rpri),
        .slow(slow), .done(done), .core_current_priority(cpri));

    task automatic final_report();
        if (bad_count == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            $display("BAD %0t got %h exp %h", $time, got, exp);
            bad_count++;
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wait_irq();
        waited = 0;
        do
            @(posedge pclk);
        while (irq !== 1'b1 && ++waited < 100);
        chk(irq, 1'b1);
    endtask

    // Clears the flags, then lets the core drop back to its old level.
    task automatic end_isr(input logic [31:0] m);
        apb(1'b1, 8'h04, m);
        done <= 1'b1;
        @(posedge pclk);
        done <= 1'b0;
    endtask

    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    initial
    begin
        #20000;
        bad_count++;
        final_report();
    end

    initial
    begin
        seed = 32'h8e6d;
        {presetn, psel, penable, pwrite, slow, done} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        pins = 5'h00;
        preq = 3'h0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 8'h00, 32'h0);
        chk(q, 32'h0);
        apb(1'b0, 8'h3c, 32'h0);
        chk(e, 1'b1);
        wd = 32'h0;
        for (int k = 0; k < 8; k++)
        begin
            pri_m[k] = 1 + (($random(seed) & 32'hff) % 7);
            wd[(k % 4) * 8 + 2 +: 3] = pri_m[k][2:0];
            if (k % 4 == 3)
                apb(1'b1, 8'h0c + 8'(k / 4) * 8'h04, wd);
        end
        apb(1'b1, 8'h08, 32'h0);
        apb(1'b1, 8'h00, 32'h1f);
        apb(1'b1, 8'h04, 32'hff);
        apb(1'b1, 8'h08, 32'hff);
        for (int m = 0; m < 2; m++)
        begin
            slow <= m[0];
            apb(1'b1, 8'h00, 32'h1f | (m << 12));
            for (int i = 0; i < 5; i++)
            begin
                pins[i] <= 1'b1;
                wait_irq();
                chk(waited < 7, 1'b1);
                chk(vec, m * i);
                chk(rpri, pri_m[i]);
                repeat (8) @(posedge pclk);
                chk(irq, 1'b0);
                end_isr(32'h1 << i);
                pins[i] <= 1'b0;
                repeat (6) @(posedge pclk);
                apb(1'b0, 8'h04, 32'h0);
                chk(q, 32'h0);
            end
        end
        apb(1'b1, 8'h1c, 32'h10);
        apb(1'b1, 8'h10, 32'h0012_1100);
        preq <= 3'h3;
        @(posedge pclk);
        preq <= 3'h0;
        wait_irq();
        chk(vec, 32'h6);
        chk(shd, 1'b1);
        repeat (8) @(posedge pclk);
        chk(irq, 1'b0);
        end_isr(32'h60);
        wd = $random(seed);
        apb(1'b1, 8'h14, wd);
        apb(1'b0, 8'h14, 32'h0);
        chk(q, wd);
        apb(1'b1, 8'h14, 32'h1e);
        apb(1'b1, 8'h00, 32'h131f);
        apb(1'b0, 8'h00, 32'h0);
        chk(q, 32'h131f);
        apb(1'b1, 8'h10, 32'h0800_0000);
        preq <= 3'h4;
        @(posedge pclk);
        preq <= 3'h0;
        repeat (6) @(posedge pclk);
        apb(1'b0, 8'h20, 32'h0);
        chk(q[1:0], 2'h2);
        wait_irq();
        chk(waited > 12, 1'b1);
        end_isr(32'h80);
        final_report();
    end
endmodule
